/* File: logic/dpsfi_top.sv */
/*
  Serial slave interface of a dual nonvolatile digital potentiometer: receives
  24-bit frames, executes them on chip-select release, drives an open-drain
  serial output for readback and chaining.
  Assumes core_clk runs well above the serial clock (at least 8 core cycles per
  serial half period) and an external pull-up on the serial output wire.
*/
`timescale 1ns/10ps
`include "dpsfi_consts.svh"

module dpsfi_top (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // serial pins
  input  wire logic         sclk,
  input  wire logic         cs_n,
  input  wire logic         sdi,
  output logic              sdo_o,
  output logic              sdo_oe,
  // wiper settings
  output logic [9:0]        wiper1,
  output logic [9:0]        wiper2
);

  // --------------------------------------------------------------------------
  // pin sampling and edge detection
  // --------------------------------------------------------------------------
  dpsfi_pkg::dpsfi_pins_t pins_s;
  logic                   sclk_q_ff;
  logic                   nxt_sclk_q;
  logic                   sck_rise;
  logic                   sck_fall;

  dpsfi_sync #(.W(3), .RSTV(`DPSFI_PIN_RST)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({sclk, cs_n, sdi}),
    .pin_out  (pins_s)
  );

  // both supported modes sample on the rising edge and shift on the falling one
  always_comb begin
    nxt_sclk_q = pins_s.sclk;
    sck_rise   = pins_s.sclk & ~sclk_q_ff;
    sck_fall   = ~pins_s.sclk & sclk_q_ff;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= nxt_sclk_q;
    end
  end

  // --------------------------------------------------------------------------
  // frame state
  // --------------------------------------------------------------------------
  dpsfi_pkg::dpsfi_state_t state_ff, nxt_state;
  logic [23:0]             sr_ff, nxt_sr, sr_eff;
  logic                    cap_ff, nxt_cap;
  logic                    pend_ff, nxt_pend;
  logic [4:0]              cnt_ff, nxt_cnt;
  logic                    any_ff, nxt_any;
  dpsfi_pkg::dpsfi_frame_t last_ff, nxt_last, efrm;
  logic                    lvld_ff, nxt_lvld;
  logic [9:0]              wip_ff [2];
  logic [9:0]              nxt_wip [2];
  logic [15:0]             nv_ff [`DPSFI_NV_WORDS];
  logic [15:0]             nxt_nv [`DPSFI_NV_WORDS];
  logic                    oe_ff, nxt_oe;
  logic                    exec;
  logic                    a0;

  // one adjust step, saturating at both ends
  function automatic logic [9:0] dpsfi_adj(input logic [3:0] cmd, input logic [9:0] w);
    logic [9:0] r;
    r = w;
    case (cmd[3:1])
      `DPSFI_ADJ_DEC6: r = w >> 1;
      `DPSFI_ADJ_DEC1: r = (w == 10'h000) ? w : w - 10'h001;
      `DPSFI_ADJ_INC6: r = w[9] ? `DPSFI_WIPER_MAX : {w[8:0], 1'b0};
      `DPSFI_ADJ_INC1: r = (w == `DPSFI_WIPER_MAX) ? w : w + 10'h001;
      default:         r = w;
    endcase
    return r;
  endfunction : dpsfi_adj

  // shifting, counting, execution on release of chip select
  always_comb begin
    nxt_state = state_ff;
    nxt_sr    = sr_ff;
    nxt_cap   = cap_ff;
    nxt_pend  = pend_ff;
    nxt_cnt   = cnt_ff;
    nxt_any   = any_ff;
    nxt_last  = last_ff;
    nxt_lvld  = lvld_ff;
    nxt_wip   = wip_ff;
    nxt_nv    = nv_ff;
    exec      = 1'b0;
    efrm      = last_ff;
    sr_eff    = pend_ff ? {sr_ff[22:0], cap_ff} : sr_ff;
    case (state_ff)
      dpsfi_pkg::DPSFI_ST_PRESET: begin
        for (int i = 0; i < 2; i++) begin
          nxt_wip[i] = nv_ff[i][9:0];
        end
        nxt_state = dpsfi_pkg::DPSFI_ST_IDLE;
      end
      dpsfi_pkg::DPSFI_ST_IDLE: begin
        if (!pins_s.cs_n) begin
          nxt_state = dpsfi_pkg::DPSFI_ST_FRAME;
        end
      end
      dpsfi_pkg::DPSFI_ST_FRAME: begin
        if (pins_s.cs_n) begin
          // a last captured bit with no falling edge is shifted in here
          nxt_sr    = sr_eff;
          nxt_pend  = 1'b0;
          nxt_state = dpsfi_pkg::DPSFI_ST_IDLE;
          if (!any_ff) begin
            exec = lvld_ff;
          end else if (cnt_ff == 5'd0) begin
            exec    = 1'b1;
            efrm    = sr_eff;
            nxt_any = 1'b0;
          end else if (cnt_ff[1:0] != 2'd0) begin
            nxt_cnt = 5'd0;
            nxt_any = 1'b0;
          end
        end else begin
          if (sck_rise) begin
            nxt_cap  = pins_s.sdi;
            nxt_pend = 1'b1;
            nxt_any  = 1'b1;
            nxt_cnt  = (cnt_ff == `DPSFI_CNT_LAST) ? 5'd0 : cnt_ff + 5'd1;
          end else if (sck_fall && pend_ff) begin
            nxt_sr   = {sr_ff[22:0], cap_ff};
            nxt_pend = 1'b0;
          end
        end
      end
      default: nxt_state = dpsfi_pkg::DPSFI_ST_IDLE;
    endcase
    a0 = efrm.address_field[0];
    if (exec) begin
      nxt_last = efrm;
      nxt_lvld = 1'b1;
      case (efrm.command_field)
        `DPSFI_CMD_NOP:     nxt_lvld = 1'b1;
        `DPSFI_CMD_RESTORE: nxt_wip[a0] = nv_ff[a0][9:0];
        `DPSFI_CMD_STORE_W: nxt_nv[a0] = {6'h00, wip_ff[a0]};
        `DPSFI_CMD_STORE_D: begin
          if (efrm.address_field != `DPSFI_ADDR_FACTORY) begin
            nxt_nv[efrm.address_field] = efrm.data_field;
          end
        end
        `DPSFI_CMD_RESET: begin
          for (int i = 0; i < 2; i++) begin
            nxt_wip[i] = nv_ff[i][9:0];
          end
        end
        `DPSFI_CMD_RD_NV:   nxt_sr[15:0] = nv_ff[efrm.address_field];
        `DPSFI_CMD_RD_W:    nxt_sr[15:0] = {6'h00, wip_ff[a0]};
        `DPSFI_CMD_WRITE:   nxt_wip[a0] = efrm.data_field[9:0];
        default: begin
          if (efrm.command_field[0]) begin
            for (int i = 0; i < 2; i++) begin
              nxt_wip[i] = dpsfi_adj(efrm.command_field, wip_ff[i]);
            end
          end else begin
            nxt_wip[a0] = dpsfi_adj(efrm.command_field, wip_ff[a0]);
          end
        end
      endcase
    end
    // pull low only for a zero msb inside a frame
    nxt_oe = (nxt_state == dpsfi_pkg::DPSFI_ST_FRAME) && !nxt_sr[23];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= dpsfi_pkg::DPSFI_ST_PRESET;
      sr_ff    <= 24'h000000;
      cap_ff   <= 1'b0;
      pend_ff  <= 1'b0;
      cnt_ff   <= 5'd0;
      any_ff   <= 1'b0;
      last_ff  <= '0;
      lvld_ff  <= 1'b0;
      oe_ff    <= 1'b0;
      // rst stands for power-up: factory contents come back
      for (int i = 0; i < 2; i++) begin
        wip_ff[i] <= `DPSFI_WIPER_MID;
      end
      for (int i = 0; i < `DPSFI_NV_WORDS; i++) begin
        nv_ff[i] <= (i < 2) ? {6'h00, `DPSFI_WIPER_MID} : `DPSFI_NV_USER_RST;
      end
    end else begin
      state_ff <= nxt_state;
      sr_ff    <= nxt_sr;
      cap_ff   <= nxt_cap;
      pend_ff  <= nxt_pend;
      cnt_ff   <= nxt_cnt;
      any_ff   <= nxt_any;
      last_ff  <= nxt_last;
      lvld_ff  <= nxt_lvld;
      oe_ff    <= nxt_oe;
      wip_ff   <= nxt_wip;
      nv_ff    <= nxt_nv;
    end
  end

  assign sdo_o  = 1'b0;
  assign sdo_oe = oe_ff;
  assign wiper1 = wip_ff[0];
  assign wiper2 = wip_ff[1];

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence s_released;
    $fell(rst);
  endsequence

  AST_PRESET: assert property (@(posedge core_clk) disable iff (rst)
    s_released |=> (wip_ff[0] == nv_ff[0][9:0]) && (wip_ff[1] == nv_ff[1][9:0]))
    else $error("wipers not preset from nonvolatile store");

  AST_CS_HIGH_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
    pins_s.cs_n [*2] |-> !sdo_oe)
    else $error("serial output driven while chip select high");

  AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (rst)
    sdo_oe |-> (sdo_o == 1'b0) && !sr_ff[23])
    else $error("serial output drives other than low");

  AST_ODD_COUNT: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == dpsfi_pkg::DPSFI_ST_FRAME) && pins_s.cs_n && (cnt_ff[1:0] != 2'd0) |=> (cnt_ff == 5'd0) && !any_ff)
    else $error("counter kept after non-multiple of four");

  AST_WRAP24: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == dpsfi_pkg::DPSFI_ST_FRAME) && !pins_s.cs_n && sck_rise && (cnt_ff == `DPSFI_CNT_LAST) |=> cnt_ff == 5'd0)
    else $error("bit counter did not wrap at 24");

  AST_EXEC_ON_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
    exec |-> pins_s.cs_n && (state_ff == dpsfi_pkg::DPSFI_ST_FRAME))
    else $error("execution without chip select release");

  AST_REPEAT: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == dpsfi_pkg::DPSFI_ST_FRAME) && pins_s.cs_n && !any_ff && lvld_ff |-> exec && (efrm == last_ff))
    else $error("bare chip select pulse did not repeat");

  AST_WRITE: assert property (@(posedge core_clk) disable iff (rst)
    exec && (efrm.command_field == `DPSFI_CMD_WRITE) |=> wip_ff[$past(a0)] == $past(efrm.data_field[9:0]))
    else $error("wiper write not loaded");

  AST_READ_WIPER: assert property (@(posedge core_clk) disable iff (rst)
    exec && (efrm.command_field == `DPSFI_CMD_RD_W) |=> sr_ff[15:0] == {6'h00, $past(wip_ff[a0])})
    else $error("read data not loaded for next frame");

  AST_FACTORY: assert property (@(posedge core_clk) disable iff (rst)
    exec && (efrm.address_field == `DPSFI_ADDR_FACTORY) |=> $stable(nv_ff[15]))
    else $error("factory word changed");

endmodule : dpsfi_top

/* File: inc/dpsfi_consts.svh */
/*
  Constants of the dual-wiper serial frame interface: frame layout, command codes,
  wiper limits and reset values.
  Assumes it is included by bare name wherever these numbers are needed.
*/
`ifndef DPSFI_CONSTS_SVH
`define DPSFI_CONSTS_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define DPSFI_FRAME_BITS   24
`define DPSFI_CNT_LAST     5'd23
`define DPSFI_WIPER_W      10
`define DPSFI_NV_WORDS     16
`define DPSFI_ADDR_FACTORY 4'hf

// ----------------------------------------------------------------------------
// command field codes
// ----------------------------------------------------------------------------
`define DPSFI_CMD_NOP      4'h0
`define DPSFI_CMD_RESTORE  4'h1
`define DPSFI_CMD_STORE_W  4'h2
`define DPSFI_CMD_STORE_D  4'h3
`define DPSFI_CMD_RESET    4'h8
`define DPSFI_CMD_RD_NV    4'h9
`define DPSFI_CMD_RD_W     4'ha
`define DPSFI_CMD_WRITE    4'hb
// adjust family, selected by command_field[3:1]
`define DPSFI_ADJ_DEC6     3'h2
`define DPSFI_ADJ_DEC1     3'h3
`define DPSFI_ADJ_INC6     3'h6
`define DPSFI_ADJ_INC1     3'h7

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define DPSFI_WIPER_MID    10'h200
`define DPSFI_WIPER_MAX    10'h3ff
`define DPSFI_NV_USER_RST  16'h0000
`define DPSFI_PIN_RST      3'h2

`endif

/* File: inc/dpsfi_pkg.sv */
/*
  Types of the dual-wiper serial frame interface.
  Assumes the constants header is compiled alongside.
*/
package dpsfi_pkg;

  // --------------------------------------------------------------------------
  // one received frame: command, address, data
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  command_field;
    logic [3:0]  address_field;
    logic [15:0] data_field;
  } dpsfi_frame_t;

  // serial pins as sampled in the core domain
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } dpsfi_pins_t;

  typedef enum logic [1:0] {
    DPSFI_ST_PRESET,
    DPSFI_ST_IDLE,
    DPSFI_ST_FRAME
  } dpsfi_state_t;

endpackage : dpsfi_pkg

/* File: logic/dpsfi_sync.sv */
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes inputs are asynchronous to core_clk; output changes only once
  the second and third stages agree.
*/
`timescale 1ns/10ps
module dpsfi_sync #(
  parameter int         W    = 3,
  parameter logic [2:0] RSTV = 3'h0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // pins and filtered result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // ----------------------------------------------------------------------------
  // agreement filter
  // ----------------------------------------------------------------------------
  // first stage is read only by the second, to keep metastability contained
  always_comb begin
    nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff  <= RSTV[W-1:0];
      s2_ff  <= RSTV[W-1:0];
      s3_ff  <= RSTV[W-1:0];
      out_ff <= RSTV[W-1:0];
    end else begin
      s1_ff  <= pin_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign pin_out = out_ff;

endmodule : dpsfi_sync

/* File: testbench/dpsfi_host.sv */
/*
  host-side serial master model: sends transfers of 0 to 48 bits in both supported clock modes.
  assumes the bench resolves the open-drain output with its pull-up and feeds the wire back here.
*/
`timescale 1ns/10ps
module dpsfi_host (
  // serial pins
  output logic        sclk,
  output logic        cs_n,
  output logic        sdi,
  input  wire logic   sdo_w,
  // captured return bits
  output logic [47:0] rx_word = 48'h0,
  output logic        rx_tgl  = 1'b0
);
  // ----------------------------------------------------------------
  // idle pins
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // whole transfer under one select; 125 ns period leaves slack for chained pull-up delay
  task automatic xfer(input logic [47:0] w, input int n, input logic pol, input logic chk);
    sclk = pol;
    #62.5 cs_n = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      sclk = 1'b0;                       // data changes on the falling edge
      sdi  = w[k];
      #62.5 sclk = 1'b1;
      rx_word = {rx_word[46:0], sdo_w};
      #62.5;
    end
    sclk = pol;
    #62.5 cs_n = 1'b1;
    sdi = ~sdi;                          // released data never holds a stale level
    if (chk) rx_tgl = ~rx_tgl;
    #62.5;
  endtask : xfer

  // clock chatter with select high
  task automatic noise;
    repeat (4) begin
      #62.5 sclk = ~sclk;
      sdi = ~sdi;
    end
  endtask : noise
endmodule : dpsfi_host

/* File: testbench/testbench.sv */
/*
  self-checking bench: host model drives frames, watchers compare wipers and returned words.
  assumes the serial output wire has a pull-up and reset equals power-up.
*/
`timescale 1ns/10ps
`include "dpsfi_consts.svh"
module testbench;
  typedef struct packed {
    logic [23:0] val;
    logic [23:0] msk;
  } dpsfi_note_t;

  logic        core_clk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo_o;
  logic        sdo_oe;
  logic        sdo_w;
  logic        rx_tgl;
  logic        pol;
  logic [9:0]  wiper1;
  logic [9:0]  wiper2;
  logic [9:0]  w1;
  logic [9:0]  w2;
  logic [19:0] ep;
  logic [19:0] seen;
  logic [47:0] rx_word;
  logic [31:0] r;
  logic [3:0]  ua;
  int          num_errors = 0;
  int          tests_run  = 0;
  logic [19:0] wq[$];
  dpsfi_note_t sq[$];

  assign sdo_w = sdo_oe ? sdo_o : 1'b1;

  dpsfi_top dpsfi_top_i (.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
                         .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper1(wiper1), .wiper2(wiper2));
  dpsfi_host dpsfi_host_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_w(sdo_w),
                           .rx_word(rx_word), .rx_tgl(rx_tgl));

  // ----------------------------------------------------------------
  // clock, compare tasks, verdict
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic cmp_wiper(input logic [19:0] e, input logic [19:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t wipers %h expected %h", $time, g, e);
    end
  endtask : cmp_wiper

  task automatic cmp_word(input dpsfi_note_t n, input logic [23:0] g);
    tests_run++;
    if ((g & n.msk) !== (n.val & n.msk)) begin
      num_errors++;
      $display("ERROR %0t word %h expected %h", $time, g, n.val);
    end
  endtask : cmp_word

  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0 && wq.size() == 0 && sq.size() == 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // wiper watcher: every change takes the oldest note; an unnoted change is a mismatch
  always @(posedge core_clk) begin
    if (rst) seen <= {10'h200, 10'h200};
    else if ({wiper1, wiper2} !== seen) begin
      seen <= {wiper1, wiper2};
      if (wq.size() == 0) cmp_wiper(seen, {wiper1, wiper2});
      else cmp_wiper(wq.pop_front(), {wiper1, wiper2});
    end
  end

  // returned word watcher; armed after time zero so the port's first value is no toggle
  initial begin
    #1;
    forever begin
      @(rx_tgl);
      if (sq.size() == 0) cmp_word({24'h0, 24'hffffff}, 24'hffffff);
      else cmp_word(sq.pop_front(), rx_word[23:0]);
    end
  end

  // ----------------------------------------------------------------
  // driver helpers
  // ----------------------------------------------------------------
  task automatic frame(input logic [47:0] w, input int n, input logic chk);
    dpsfi_host_i.xfer(w, n, pol, chk);
    repeat (20) @(posedge core_clk);
    #1;
  endtask : frame

  // notes a wiper pair only when it really moves
  task automatic note_w;
    if ({w1, w2} !== ep) begin
      ep = {w1, w2};
      wq.push_back(ep);
    end
  endtask : note_w

  task automatic wr(input logic a0, input logic [15:0] d);
    if (a0) w2 = d[9:0];
    else w1 = d[9:0];
    note_w();
    frame({24'h0, `DPSFI_CMD_WRITE, 3'h0, a0, d}, 24, 1'b0);
  endtask : wr

  // read, then a nop frame carries the answer back
  task automatic rd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    frame({24'h0, c, a, 16'h0}, 24, 1'b0);
    sq.push_back({c, a, e, 8'hff, m});
    frame(48'h0, 24, 1'b1);
  endtask : rd

  // plain command frame whose wiper result was noted beforehand
  task automatic op(input logic [3:0] c, input logic [3:0] a);
    note_w();
    frame({24'h0, c, a, 16'h0}, 24, 1'b0);
  endtask : op

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pol = 1'b0;
    w1  = 10'h200;
    w2  = 10'h200;
    ep  = {w1, w2};
    r   = $urandom(32'h6dd31bb4);
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    cmp_wiper({10'h200, 10'h200}, {wiper1, wiper2});
    frame(48'h0, 0, 1'b0);  // bare pulse right after power-up changes nothing
    for (int m = 0; m < 2; m++) begin
      pol = m[0];
      for (int a = 0; a < 2; a++) begin
        r = $urandom;
        wr(a[0], r[15:0]);
        rd(`DPSFI_CMD_RD_W, {3'h0, a[0]}, {6'h0, a[0] ? w2 : w1}, 16'h03ff);
      end
      ua = 4'(2 + ($urandom % 13));
      r = $urandom;
      frame({24'h0, `DPSFI_CMD_STORE_D, ua, r[15:0]}, 24, 1'b0);
      rd(`DPSFI_CMD_RD_NV, ua, r[15:0], 16'hffff);
      frame({24'h0, `DPSFI_CMD_STORE_D, 4'hf, r[31:16]}, 24, 1'b0);
      rd(`DPSFI_CMD_RD_NV, 4'hf, 16'h0000, 16'hffff);
      // two chained frames: the first passes through, the second executes here
      r = $urandom;
      w2 = r[9:0];
      note_w();
      sq.push_back({`DPSFI_CMD_WRITE, 4'h0, 6'h0, r[25:16], 24'hffffff});
      frame({`DPSFI_CMD_WRITE, 4'h0, 6'h0, r[25:16], `DPSFI_CMD_WRITE, 4'h1, 6'h0, r[9:0]}, 48, 1'b1);
      wr(1'b0, 16'h0100);
      w1 = 10'h101;
      note_w();
      frame({24'h0, 4'he, 4'h0, 16'h0}, 24, 1'b0);
      w1 = 10'h102;
      note_w();
      frame(48'h0, 0, 1'b0);
      frame({23'h0, 1'b0, `DPSFI_CMD_WRITE, 4'h0, 16'h0155}, 25, 1'b0);
      frame({24'h0, `DPSFI_CMD_WRITE, 4'h0, 15'h0155}, 23, 1'b0);
      wr(1'b0, 16'h02aa);
      // store, adjust, restore and reset: every wiper move is noted first
      frame({24'h0, `DPSFI_CMD_STORE_W, 4'h0, 16'h0}, 24, 1'b0);
      rd(`DPSFI_CMD_RD_NV, 4'h0, 16'h02aa, 16'hffff);
      wr(1'b0, 16'h0040);
      w2 = w2 >> 1;
      op(4'h4, 4'h1);
      w1 = w1 - 10'h001;
      w2 = (w2 == 10'h000) ? w2 : w2 - 10'h001;
      op(4'h7, 4'h0);
      w1 = 10'h07e;
      op(4'hc, 4'h0);
      w1 = 10'h2aa;
      op(`DPSFI_CMD_RESTORE, 4'h0);
      w2 = 10'h200;
      op(`DPSFI_CMD_RESET, 4'h0);
      dpsfi_host_i.noise();
      repeat (20) @(posedge core_clk);
      cmp_word({24'h0, 24'h1}, {23'h0, sdo_oe});
    end
    repeat (50) @(posedge core_clk);
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule : testbench
